// file: bcc_consts.svh
// Purpose: constants for the brushless commutation controller
// Assumes: 50 MHz mclk
// Notes: ramp and pulse counts are defaults; the top module exposes them as parameters
`ifndef BCC_CONSTS_SVH
`define BCC_CONSTS_SVH
`define BCC_CLK_HZ 50000000
`define BCC_RAMP_MAX_HZ 250000
// fastest ramp: half period of one 250 kHz cycle, in clock cycles
`define BCC_RAMP_MIN_HALF (`BCC_CLK_HZ / `BCC_RAMP_MAX_HZ / 2)
// triangle valley and peak in units of 10 mV (2.5 V and 7.5 V)
`define BCC_RAMP_VALLEY 16'h00FA
`define BCC_RAMP_PEAK 16'h02EE
`define BCC_RAMP_STEP 16'h0001
// clock cycles per ramp step; 500 steps a half period gives a 50 kHz triangle
`define BCC_RAMP_STEP_DIV 1
`define BCC_PULSE_CYCLES 1000
`define BCC_PULSE_W 16
`endif

// file: bcc_pkg.sv
// Purpose: types for the brushless commutation controller
// Assumes: nothing
// Notes: drive words group the six phase switch commands
package bcc_pkg;
   typedef struct packed {
      logic [2:0] upper;
      logic [2:0] lower;
   } bcc_drive_t;
   typedef enum logic {BCC_RISE, BCC_FALL} bcc_ramp_dir_t;
endpackage : bcc_pkg

// file: bcc_ramp.sv
// Purpose: digital triangle ramp with sync restart
// Assumes: ramp_sync_input synchronous to mclk
// Notes: ramp value is in 10 mV steps between valley and peak
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.svh"
module bcc_ramp #(
   parameter int STEP_DIV = `BCC_RAMP_STEP_DIV
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // sync
   input wire logic ramp_sync_input,
   // ramp out
   output logic [15:0] ramp_value,
   output logic ramp_falling
);
   // the divider is 16 bits wide
   if (STEP_DIV < 1 || STEP_DIV > 65536) begin : g_bad_div
      $error("STEP_DIV out of range for the divider");
   end
   typedef struct packed {
      logic [15:0] value;
      bcc_pkg::bcc_ramp_dir_t dir;
      logic [15:0] div;
      logic sync_d;
   } bcc_ramp_st_t;
   bcc_ramp_st_t st_r;
   bcc_ramp_st_t st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync_d = ramp_sync_input;
      if (st_r.div >= 16'(STEP_DIV - 1)) begin
         st_nxt.div = 16'h0000;
         if (st_r.dir == bcc_pkg::BCC_RISE) begin
            if (st_r.value >= `BCC_RAMP_PEAK - `BCC_RAMP_STEP) begin // RULE14
               st_nxt.value = `BCC_RAMP_PEAK;
               st_nxt.dir = bcc_pkg::BCC_FALL;
            end else begin
               st_nxt.value = st_r.value + `BCC_RAMP_STEP;
            end
         end else begin
            if (st_r.value <= `BCC_RAMP_VALLEY + `BCC_RAMP_STEP) begin // RULE14
               st_nxt.value = `BCC_RAMP_VALLEY;
               st_nxt.dir = bcc_pkg::BCC_RISE;
            end else begin
               st_nxt.value = st_r.value - `BCC_RAMP_STEP;
            end
         end
      end else begin
         st_nxt.div = st_r.div + 16'h0001;
      end
      // a sync edge wins over the valley turnaround; later edges while falling only restart the step divider
      if (ramp_sync_input && !st_r.sync_d) begin
         st_nxt.dir = bcc_pkg::BCC_FALL; // RULE15
         st_nxt.div = 16'h0000;
      end
   end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '{value: `BCC_RAMP_VALLEY, dir: bcc_pkg::BCC_RISE, div: 16'h0000, sync_d: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign ramp_value = st_r.value;
   assign ramp_falling = (st_r.dir == bcc_pkg::BCC_FALL);
endmodule : bcc_ramp
`default_nettype wire

// file: bcc_commutation.sv
// Behaviour
// [RULE1] brake: uppers off, lowers on
// [RULE2] speed pulse keeps running during brake
// [RULE3] brake lowers gated only by fault, pwm, coast; the code also turns them off on supply_lockout
// [RULE4] coast disables all six drives
// [RULE5] rotation command selects decode order
// [RULE6] sense derived from valid sensor transitions
// [RULE7] sense matches command while motoring
// [RULE8] two-quadrant: pwm gates lowers only
// [RULE9] four-quadrant: pwm gates uppers and lowers
// [RULE10] speed pulse retriggers on commutation change
// [RULE11] retrigger restarts pulse on-time
// [RULE12] supply lockout holds all drives off
// [RULE13] sensors never all high or low
// [RULE14] triangle ramp between valley and peak
// [RULE15] sync rising edge starts ramp fall
// [RULE16] own ramp slightly slower than master
// [RULE17] sync held low when unused
// [RULE18] one upper, one other-phase lower on
// [RULE19] invalid sensor state turns drives off
// [RULE20] coast/lockout over brake over commutation
//
// Purpose: brushless motor commutation, gating, direction and speed pulse
// Assumes: all inputs synchronous to mclk; analog comparisons done outside
// Notes: pwm_on high means the on-phase of the modulator
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.svh"
module bcc_commutation #(
   parameter int PULSE_CYCLES = `BCC_PULSE_CYCLES,
   parameter int RAMP_STEP_DIV = `BCC_RAMP_STEP_DIV
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // rotor sensors
   input wire logic rotor_sensor_a,
   input wire logic rotor_sensor_b,
   input wire logic rotor_sensor_c,
   // commands
   input wire logic rotation_cmd,
   input wire logic brake_req,
   input wire logic coast_req,
   input wire logic supply_lockout,
   input wire logic overcurrent_trip,
   input wire logic chop_four_quad,
   // modulator
   input wire logic ramp_sync_input,
   input wire logic [15:0] modulator_plus_input,
   output logic [15:0] ramp_value,
   // phase drives
   output logic phase_a_upper_drive,
   output logic phase_b_upper_drive,
   output logic phase_c_upper_drive,
   output logic phase_a_lower_drive,
   output logic phase_b_lower_drive,
   output logic phase_c_lower_drive,
   // status
   output logic rotation_sense,
   output logic speed_pulse_out
);
   // the pulse counter is only BCC_PULSE_W bits wide
   if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << `BCC_PULSE_W)) begin : g_bad_pulse
      $error("PULSE_CYCLES out of range");
   end
   if (RAMP_STEP_DIV < 1) begin : g_bad_div
      $error("RAMP_STEP_DIV must be at least 1");
   end
   // a half swing may not be shorter than the highest ramp frequency allows
   if ((`BCC_RAMP_PEAK - `BCC_RAMP_VALLEY) * RAMP_STEP_DIV < `BCC_RAMP_MIN_HALF) begin : g_too_fast
      $error("RAMP_STEP_DIV gives a ramp above the highest frequency");
   end

   // ramp_value is exported so the modulator level can be set against the triangle
   bcc_ramp #(.STEP_DIV(RAMP_STEP_DIV)) u_ramp (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ramp_sync_input(ramp_sync_input),
      .ramp_value(ramp_value),
      .ramp_falling()
   );

   // position index 0..5 in forward order; 3'h7 marks an invalid code
   function automatic logic [2:0] hall_pos(input logic [2:0] h);
      case (h)
         3'h5: hall_pos = 3'h0;
         3'h4: hall_pos = 3'h1;
         3'h6: hall_pos = 3'h2;
         3'h2: hall_pos = 3'h3;
         3'h3: hall_pos = 3'h4;
         3'h1: hall_pos = 3'h5;
         default: hall_pos = 3'h7; // RULE13
      endcase
   endfunction : hall_pos

   // next position along the forward or the reverse order, wrapping at six
   function automatic logic [2:0] pos_step(input logic [2:0] p, input logic up);
      if (up) begin
         pos_step = (p == 3'h5) ? 3'h0 : p + 3'h1;
      end else begin
         pos_step = (p == 3'h0) ? 3'h5 : p - 3'h1;
      end
   endfunction : pos_step

   // one-hot phase for a position: with rotation_cmd high, upper follows p, lower follows p+2 (mod 6)
   function automatic logic [2:0] phase_of(input logic [2:0] p);
      case (p)
         3'h0, 3'h1: phase_of = 3'h1;
         3'h2, 3'h3: phase_of = 3'h2;
         3'h4, 3'h5: phase_of = 3'h4;
         default: phase_of = 3'h0;
      endcase
   endfunction : phase_of

   // a drive word passes only in the modulator on-time with no current trip
   function automatic logic [2:0] chop_gate(input logic [2:0] d, input logic gate);
      if (gate) begin
         chop_gate = d;
      end else begin
         chop_gate = 3'h0;
      end
   endfunction : chop_gate

   // the previous sensor code is both the pulse trigger and the direction reference
   typedef struct packed {
      logic [2:0] hall_prev;
      logic sense;
      logic [`BCC_PULSE_W-1:0] pulse_cnt;
      bcc_pkg::bcc_drive_t drive;
   } bcc_st_t;
   bcc_st_t st_r;
   bcc_st_t st_nxt;

   logic [2:0] hall;
   logic [2:0] pos;
   logic [2:0] pos_prev;
   logic pwm_on;
   logic pos_valid;
   logic prev_valid;
   logic chop_ok;
   bcc_pkg::bcc_drive_t comm;
   assign hall = {rotor_sensor_a, rotor_sensor_b, rotor_sensor_c};
   assign pos = hall_pos(hall);
   assign pos_prev = hall_pos(st_r.hall_prev);
   // strict compare: a level equal to the ramp counts as the off-time
   assign pwm_on = (modulator_plus_input > ramp_value);
   assign pos_valid = (pos != 3'h7);
   assign prev_valid = (pos_prev != 3'h7);
   // the compare is combinational so the gate is set in the cycle of the ramp crossing and reaches the drives one edge later
   assign chop_ok = pwm_on && !overcurrent_trip;

   // commutation word before any gating or priority
   always_comb begin
      comm.upper = 3'h0;
      comm.lower = 3'h0;
      if (pos_valid) begin
         // reversing swaps the upper and lower sets
         if (rotation_cmd) begin // RULE5
            comm.upper = phase_of(pos); // RULE18
            comm.lower = phase_of(pos_step(pos_step(pos, 1'b1), 1'b1));
         end else begin
            comm.lower = phase_of(pos);
            comm.upper = phase_of(pos_step(pos_step(pos, 1'b1), 1'b1));
         end
      end
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.hall_prev = hall;
      // sense follows the rotor, not the command, so a reversal shows once the rotor turns
      if (pos_valid && prev_valid && pos != pos_prev) begin
         // only adjacent codes count; a skipped state carries no direction
         if (pos == pos_step(pos_prev, 1'b1)) st_nxt.sense = 1'b1; // RULE6 RULE7
         else if (pos == pos_step(pos_prev, 1'b0)) st_nxt.sense = 1'b0; // RULE6
      end
      // brake does not touch this counter
      // an invalid code still counts as a change and fires the pulse
      if (hall != st_r.hall_prev) begin
         st_nxt.pulse_cnt = `BCC_PULSE_W'(PULSE_CYCLES); // RULE10 RULE11 RULE2
      end else if (st_r.pulse_cnt != '0) begin
         st_nxt.pulse_cnt = st_r.pulse_cnt - `BCC_PULSE_W'(1);
      end
      if (coast_req || supply_lockout) begin
         st_nxt.drive = '0; // RULE4 RULE12 RULE20
      end else if (brake_req) begin
         st_nxt.drive.upper = 3'h0; // RULE1 RULE20
         // all lowers share the chopping gate so the braking current stays limited
         st_nxt.drive.lower = chop_gate(3'h7, chop_ok); // RULE3
      end else if (!pos_valid) begin
         st_nxt.drive = '0; // RULE19
      end else begin
         st_nxt.drive.lower = chop_gate(comm.lower, chop_ok); // RULE8
         if (chop_four_quad) begin
            st_nxt.drive.upper = chop_gate(comm.upper, chop_ok); // RULE9
         end else begin
            // uppers stay on through the off-time so current freewheels in the upper bridge
            st_nxt.drive.upper = comm.upper; // RULE8
         end
      end
   end

   // one register stage: every output but speed_pulse_out is a flop, so drives lag their causes by a cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '{hall_prev: 3'h0, sense: 1'b0, pulse_cnt: '0, drive: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // drive bit 2 is phase a, bit 0 is phase c
   assign phase_a_upper_drive = st_r.drive.upper[2];
   assign phase_b_upper_drive = st_r.drive.upper[1];
   assign phase_c_upper_drive = st_r.drive.upper[0];
   assign phase_a_lower_drive = st_r.drive.lower[2];
   assign phase_b_lower_drive = st_r.drive.lower[1];
   assign phase_c_lower_drive = st_r.drive.lower[0];
   assign rotation_sense = st_r.sense;
   assign speed_pulse_out = (st_r.pulse_cnt != '0);
endmodule : bcc_commutation
`default_nettype wire

// file: bcc_rotor.sv
// Purpose: rotor sensor model for the commutation controller
// Assumes: one sector per step request
// Notes: bad forces the all-high code on request
`timescale 1ns/1ps
`default_nettype none
module bcc_rotor (
   // control
   input wire logic mclk,
   input wire logic step,
   input wire logic fwd,
   input wire logic bad,
   // sensors
   output logic [2:0] pos,
   output logic rotor_sensor_a,
   output logic rotor_sensor_b,
   output logic rotor_sensor_c
);
   localparam logic [2:0] CODE [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
   initial pos = 3'h0;
   always @(posedge mclk) begin
      if (step) pos <= fwd ? (pos == 3'h5 ? 3'h0 : pos + 3'h1) : (pos == 3'h0 ? 3'h5 : pos - 3'h1);
   end
   assign {rotor_sensor_a, rotor_sensor_b, rotor_sensor_c} = bad ? 3'h7 : CODE[pos];
endmodule : bcc_rotor
`default_nettype wire

// file: bcc_commutation_assertions.sv
// Purpose: port assertions for the commutation controller
// Assumes: single mclk domain
// Notes: checks other than ramp_bound_a start two edges after reset so history is clean
`timescale 1ns/1ps
`default_nettype none
module bcc_chk (
   // clock, reset and inputs
   input wire logic mclk, sys_rst, rotor_sensor_a, rotor_sensor_b, rotor_sensor_c,
   input wire logic brake_req, coast_req, supply_lockout, overcurrent_trip, chop_four_quad,
   input wire logic [15:0] modulator_plus_input,
   // outputs
   input wire logic [15:0] ramp_value,
   input wire logic phase_a_upper_drive, phase_b_upper_drive, phase_c_upper_drive,
   input wire logic phase_a_lower_drive, phase_b_lower_drive, phase_c_lower_drive, speed_pulse_out
);
   logic [1:0] live_r;
   logic [2:0] up, lo, hs;
   logic run, on;
   assign up = {phase_a_upper_drive, phase_b_upper_drive, phase_c_upper_drive};
   assign lo = {phase_a_lower_drive, phase_b_lower_drive, phase_c_lower_drive};
   assign hs = {rotor_sensor_a, rotor_sensor_b, rotor_sensor_c};
   assign run = !coast_req && !supply_lockout;
   assign on = modulator_plus_input > ramp_value;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) live_r <= 2'h0;
      else live_r <= {live_r[0], 1'b1};
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence s_change;
      live_r[1] && $past(hs) != $past(hs, 2);
   endsequence
   brake_upper_a: assert property (live_r[1] && $past(brake_req && run) |-> up == 3'h0)
      else $error("upper drive on in brake");
   brake_lower_a: assert property (live_r[1] && $past(brake_req && run && !overcurrent_trip && on) |-> lo == 3'h7)
      else $error("lower drive off in brake");
   coast_off_a: assert property (live_r[1] && $past(coast_req) |-> {up, lo} == 6'h00)
      else $error("drive on in coast");
   lockout_off_a: assert property (live_r[1] && $past(supply_lockout) |-> {up, lo} == 6'h00)
      else $error("drive on in lockout");
   invalid_off_a: assert property (live_r[1] && $past(!brake_req && (hs == 3'h0 || hs == 3'h7)) |-> {up, lo} == 6'h00)
      else $error("drive on for bad code");
   two_quad_a: assert property (live_r[1] && $past(!brake_req && run && !chop_four_quad && hs != 3'h0 && hs != 3'h7)
      |-> $onehot(up))
      else $error("upper gated in two-quadrant");
   pulse_hold_a: assert property (s_change |-> speed_pulse_out [*8])
      else $error("speed pulse short");
   ramp_bound_a: assert property (ramp_value >= 16'h00FA && ramp_value <= 16'h02EE)
      else $error("ramp out of range");
endmodule : bcc_chk
bind bcc_commutation bcc_chk u_chk (.mclk, .sys_rst, .rotor_sensor_a, .rotor_sensor_b, .rotor_sensor_c,
   .brake_req, .coast_req, .supply_lockout, .overcurrent_trip, .chop_four_quad, .modulator_plus_input,
   .ramp_value, .phase_a_upper_drive, .phase_b_upper_drive, .phase_c_upper_drive, .phase_a_lower_drive,
   .phase_b_lower_drive, .phase_c_lower_drive, .speed_pulse_out);
`default_nettype wire

// file: bcc_commutation_tb.sv
// Purpose: self-checking bench for the commutation controller
// Assumes: rotor model steps one sector per request
// Notes: a short pulse count keeps the run brief; the ramp step divider stays at its default of 1
`timescale 1ns/1ps
`default_nettype none
module bcc_commutation_tb;
   logic mclk = 1'b0, sys_rst = 1'b1, step, fwd, bad, rotation_cmd, brake_req, coast_req, supply_lockout;
   logic overcurrent_trip, chop_four_quad, ramp_sync_input, rotation_sense, speed_pulse_out;
   logic phase_a_upper_drive, phase_b_upper_drive, phase_c_upper_drive;
   logic phase_a_lower_drive, phase_b_lower_drive, phase_c_lower_drive;
   logic rotor_sensor_a, rotor_sensor_b, rotor_sensor_c;
   logic [15:0] modulator_plus_input, ramp_value, ramp_seen;
   logic [2:0] pos;
   logic [5:0] drv;
   int n_mismatch = 0, cmp_count = 0;
   assign drv = {phase_a_upper_drive, phase_b_upper_drive, phase_c_upper_drive,
      phase_a_lower_drive, phase_b_lower_drive, phase_c_lower_drive};
   always #10 mclk = ~mclk;
   bcc_rotor rotor (.mclk, .step, .fwd, .bad, .pos, .rotor_sensor_a, .rotor_sensor_b, .rotor_sensor_c);
   bcc_commutation #(.PULSE_CYCLES(10), .RAMP_STEP_DIV(1)) dut (.mclk, .sys_rst, .rotor_sensor_a,
      .rotor_sensor_b, .rotor_sensor_c, .rotation_cmd, .brake_req, .coast_req, .supply_lockout,
      .overcurrent_trip, .chop_four_quad, .ramp_sync_input, .modulator_plus_input, .ramp_value,
      .phase_a_upper_drive, .phase_b_upper_drive, .phase_c_upper_drive, .phase_a_lower_drive,
      .phase_b_lower_drive, .phase_c_lower_drive, .rotation_sense, .speed_pulse_out);
   function automatic logic [5:0] exp_drv(logic [2:0] p, logic c, logic q, logic on);
      logic [2:0] u, l, t;
      // bit 0 is phase c: positions 0 and 1 drive phase c high in the forward order
      u = 3'h1 << (p / 3'h2);
      l = 3'h1 << (((p + 3'h2) % 3'h6) / 3'h2);
      if (!c) begin
         t = u;
         u = l;
         l = t;
      end
      return {(on || !q) ? u : 3'h0, on ? l : 3'h0};
   endfunction : exp_drv
   task automatic chk(string nm, logic [5:0] seen, logic [5:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, want, seen);
      end
   endtask : chk
   task automatic st(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : st
   // a step request lasts one edge; sensors move on the next
   task automatic mv(logic d);
      @(posedge mclk);
      fwd <= d;
      step <= 1'b1;
      @(posedge mclk);
      step <= 1'b0;
   endtask : mv
   task automatic wrap_up();
      if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   initial begin
      {step, fwd, bad, rotation_cmd, brake_req, coast_req, supply_lockout} = '0;
      {overcurrent_trip, chop_four_quad, ramp_sync_input} = '0;
      modulator_plus_input = 16'hFFFF;
      void'($urandom(96));
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int p = 0; p < 6; p++) begin
         for (int k = 0; k < 8; k++) begin
            @(posedge mclk);
            rotation_cmd <= k[0];
            chop_four_quad <= k[1];
            modulator_plus_input <= k[2] ? 16'hFFFF : 16'h0000;
            st(2);
            chk("drive", drv, exp_drv(pos, k[0], k[1], k[2]));
         end
         mv(1'b1);
         st(2);
         chk("sense_pulse", {4'h0, rotation_sense, speed_pulse_out}, 6'h03);
      end
      mv(1'b0);
      st(2);
      chk("sense_back", {4'h0, rotation_sense, speed_pulse_out}, 6'h01);
      st(14);
      mv(1'b1);
      st(4);
      mv(1'b1);
      st(6);
      chk("retrigger", {5'h00, speed_pulse_out}, 6'h01);
      st(12);
      chk("pulse_end", {5'h00, speed_pulse_out}, 6'h00);
      @(posedge mclk);
      brake_req <= 1'b1;
      st(2);
      chk("brake", drv, 6'h07);
      @(posedge mclk);
      overcurrent_trip <= 1'b1;
      st(2);
      chk("brake_trip", drv, 6'h00);
      @(posedge mclk);
      overcurrent_trip <= 1'b0;
      mv(1'b1);
      st(2);
      chk("brake_pulse", {5'h00, speed_pulse_out}, 6'h01);
      for (int j = 1; j < 4; j++) begin
         @(posedge mclk);
         coast_req <= j[0];
         supply_lockout <= j[1];
         st(2);
         chk("off", drv, 6'h00);
      end
      @(posedge mclk);
      {coast_req, supply_lockout, brake_req, bad} <= 4'h1;
      st(3);
      chk("bad_code", drv, 6'h00);
      bad <= 1'b0;
      // a master sync a little faster than the own 1000-cycle ramp
      repeat (3) begin
         @(posedge mclk);
         ramp_sync_input <= 1'b1;
         st(2);
         ramp_seen = ramp_value;
         st(1);
         chk("ramp_fall", 6'(ramp_seen - ramp_value), 6'h01);
         @(posedge mclk);
         ramp_sync_input <= 1'b0;
         repeat (900) @(posedge mclk);
      end
      repeat (300) begin
         @(posedge mclk);
         rotation_cmd <= 1'($urandom_range(1));
         chop_four_quad <= 1'($urandom_range(1));
         overcurrent_trip <= ($urandom_range(7) == 0);
         brake_req <= ($urandom_range(7) == 0);
         coast_req <= ($urandom_range(15) == 0);
         ramp_sync_input <= 1'($urandom_range(1));
         modulator_plus_input <= 16'($urandom_range(1000));
         mv(1'($urandom_range(1)));
      end
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      wrap_up();
   end
endmodule : bcc_commutation_tb
`default_nettype wire
